// File: hdl/cab_alu_branch.sv
`timescale 1ns/1ps
// Operation
// RULE1 - Word add immediate, no H, 2 cycles
// RULE2 - Word subtract immediate, no H, 2 cycles
// RULE3 - Subtract immediate with borrow, updates H S V N Z C, 1 cycle
// RULE4 - AND immediate, keeps C and H
// RULE5 - OR immediate, updates Z N V S
// RULE6 - Set bits by mask, updates Z N V S
// RULE7 - Test register, value kept, flags set
// RULE8 - Signed by unsigned multiply into pair, 2 cycles
// RULE9 - Fractional multiplies shift product left one
// RULE10 - Indirect jump loads Z, clears high bits
// RULE11 - Indirect call loads Z, 3 or 4 cycles
// RULE12 - Compare skip if equal, no flags
// RULE13 - Skip when register bit is clear
// RULE14 - Skip when I/O bit set, no flags
// RULE15 - Branch on flag set, relative target
// RULE16 - Signed greater-or-equal when N xor V zero
// RULE17 - Signed less-than when N xor V one
// RULE18 - Unsigned same-or-higher when carry clear
// RULE19 - Branch when half-carry is set
// RULE20 - Branch when overflow is set
// RULE21 - Branch when interrupts enabled, flags unchanged
// RULE22 - Wide program counter takes longer call
// RULE23 - Skip costs one or two extra cycles
module cab_alu_branch
  import cab_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            resetn_i,
  input  wire logic            cmd_valid_i,
  input  wire cab_pkg::cab_cmd_t cmd_i,
  output logic                 ready_o,
  output cab_pkg::cab_res_t    res_o,
  output logic [7:0]           status_o,
  input  wire logic [1:0]      reg_addr_i,
  input  wire logic [7:0]      reg_wdata_i,
  input  wire logic            reg_we_i,
  input  wire logic            reg_re_i,
  output logic [7:0]           reg_rdata_o
);
  import cab_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic              take;
  logic              fin;
  logic [2:0]        cnt;
  logic [2:0]        next_n;
  cab_res_t          next_res;
  cab_res_t          pend_res;
  logic [7:0]        next_status_register;
  logic [7:0]        pend_status_register;
  logic [7:0]        ctrl;
  logic [7:0]        lastcyc;
  logic              pc_wide;
  logic [15:0]       w_add;
  logic [15:0]       w_sub;
  logic [7:0]        sbc_r;
  logic [7:0]        log_r;
  logic [15:0]       p_su;
  logic [15:0]       p_ss;
  logic [15:0]       p_frac;
  logic [PC_W-1:0]   pc_inc;
  logic [PC_W-1:0]   pc_rel;
  logic [PC_W-1:0]   pc_skip;
  logic              br_cond;
  logic              skip_hit;
  logic              is_logic;
  logic              is_skip;

  assign take    = cmd_valid_i & ready_o;
  assign pc_wide = ctrl[CTRL_PCWIDE];

  // ------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------
  assign w_add  = cmd_i.pair + {10'h000, cmd_i.imm[5:0]};                  // [RULE1]
  assign w_sub  = cmd_i.pair - {10'h000, cmd_i.imm[5:0]};                  // [RULE2]
  assign sbc_r  = cmd_i.rd - cmd_i.imm - {7'h00, status_o[FLAG_C]};        // [RULE3]
  assign p_su   = 16'($signed({{8{cmd_i.rd[7]}}, cmd_i.rd}) *
                      $signed({8'h00, cmd_i.rr}));                         // [RULE8]
  assign p_ss   = 16'($signed({{8{cmd_i.rd[7]}}, cmd_i.rd}) *
                      $signed({{8{cmd_i.rr[7]}}, cmd_i.rr}));
  // Fractional forms share the multipliers, only the shift differs
  assign p_frac = (cmd_i.op == OP_FRAC_MUL_SIGNED) ? p_ss : p_su;          // [RULE9]
  assign pc_inc  = cmd_i.pc + 22'h000001;
  assign pc_rel  = cmd_i.pc + {{15{cmd_i.offset[6]}}, cmd_i.offset} + 22'h000001;
  assign pc_skip = cmd_i.pc + (cmd_i.next_two_word ? 22'h000003 : 22'h000002);
  assign is_logic = (cmd_i.op == OP_AND_IMM) || (cmd_i.op == OP_OR_IMM) ||
                    (cmd_i.op == OP_SET_BITS_MASKED) || (cmd_i.op == OP_TEST_REG);
  assign is_skip  = (cmd_i.op == OP_COMPARE_SKIP_EQUAL) ||
                    (cmd_i.op == OP_SKIP_REG_BIT_CLEAR) || (cmd_i.op == OP_SKIP_IO_BIT_SET);

  always_comb begin
    unique case (cmd_i.op)
      OP_AND_IMM:  log_r = cmd_i.rd & cmd_i.imm;                           // [RULE4]
      OP_TEST_REG: log_r = cmd_i.rd & cmd_i.rd;                            // [RULE7]
      default:     log_r = cmd_i.rd | cmd_i.imm;                           // [RULE5] [RULE6]
    endcase
  end

  always_comb begin
    unique case (cmd_i.op)
      OP_COMPARE_SKIP_EQUAL: skip_hit = (cmd_i.rd == cmd_i.rr);            // [RULE12]
      OP_SKIP_REG_BIT_CLEAR: skip_hit = ~cmd_i.rd[cmd_i.bitsel];           // [RULE13]
      OP_SKIP_IO_BIT_SET:    skip_hit = cmd_i.io_val[cmd_i.bitsel];        // [RULE14]
      default:               skip_hit = 1'b0;
    endcase
  end

  always_comb begin
    unique case (cmd_i.op)
      OP_BRANCH_FLAG_SET:      br_cond = status_o[cmd_i.bitsel];           // [RULE15]
      OP_BRANCH_SIGNED_GE:     br_cond = ~(status_o[FLAG_N] ^ status_o[FLAG_V]); // [RULE16]
      OP_BRANCH_SIGNED_LT:     br_cond = status_o[FLAG_N] ^ status_o[FLAG_V];    // [RULE17]
      OP_BRANCH_UNSIGNED_GE:   br_cond = ~status_o[FLAG_C];                // [RULE18]
      OP_BRANCH_HALFCARRY_SET: br_cond = status_o[FLAG_H];                 // [RULE19]
      OP_BRANCH_OVERFLOW_SET:  br_cond = status_o[FLAG_V];                 // [RULE20]
      OP_BRANCH_IRQ_ENABLED:   br_cond = status_o[FLAG_I];                 // [RULE21]
      default:                 br_cond = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Result, flags and cycle count per operation
  // ------------------------------------------------------------
  always_comb begin
    next_res         = '0;
    next_res.done    = 1'b1;
    next_res.pc      = pc_inc;
    next_res.ret_pc  = pc_inc;
    next_status_register        = status_o;
    next_n           = CYC_BASE;
    if (is_logic) begin
      next_res.data[7:0] = log_r;
      next_res.wr_lo     = (cmd_i.op != OP_TEST_REG);                      // [RULE7]
      next_status_register[FLAG_Z]  = (log_r == 8'h00);                               // [RULE4] [RULE5]
      next_status_register[FLAG_N]  = log_r[7];
      next_status_register[FLAG_V]  = 1'b0;
      next_status_register[FLAG_S]  = log_r[7];                                       // [RULE6]
    end
    if (is_skip && skip_hit) begin
      // The skipped word count decides both target and cost
      next_res.pc      = pc_skip;
      next_res.pc_load = 1'b1;
      next_n = cmd_i.next_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE;          // [RULE23]
    end
    if (br_cond) begin
      next_res.pc      = pc_rel;                                           // [RULE15]
      next_res.pc_load = 1'b1;
      next_n           = CYC_BR_TAKEN;
    end
    unique case (cmd_i.op)
      OP_ADD_IMM_WORD: begin
        next_res.data     = w_add;
        next_res.wr_lo    = 1'b1;
        next_res.wr_hi    = 1'b1;
        next_status_register[FLAG_Z] = (w_add == 16'h0000);
        next_status_register[FLAG_N] = w_add[15];
        next_status_register[FLAG_V] = ~cmd_i.pair[15] & w_add[15];
        next_status_register[FLAG_C] = cmd_i.pair[15] & ~w_add[15];
        next_status_register[FLAG_S] = w_add[15] ^ (~cmd_i.pair[15] & w_add[15]);
        next_n            = CYC_WORD;                                      // [RULE1]
      end
      OP_SUB_IMM_WORD: begin
        next_res.data     = w_sub;
        next_res.wr_lo    = 1'b1;
        next_res.wr_hi    = 1'b1;
        next_status_register[FLAG_Z] = (w_sub == 16'h0000);
        next_status_register[FLAG_N] = w_sub[15];
        next_status_register[FLAG_V] = cmd_i.pair[15] & ~w_sub[15];
        next_status_register[FLAG_C] = w_sub[15] & ~cmd_i.pair[15];
        next_status_register[FLAG_S] = w_sub[15] ^ (cmd_i.pair[15] & ~w_sub[15]);
        next_n            = CYC_WORD;                                      // [RULE2]
      end
      OP_SUB_IMM_BORROW: begin
        next_res.data[7:0] = sbc_r;
        next_res.wr_lo     = 1'b1;
        // Zero only stays set across a multi-byte chain
        next_status_register[FLAG_Z]  = (sbc_r == 8'h00) & status_o[FLAG_Z];          // [RULE3]
        next_status_register[FLAG_N]  = sbc_r[7];
        next_status_register[FLAG_V]  = (cmd_i.rd[7] & ~cmd_i.imm[7] & ~sbc_r[7]) |
                             (~cmd_i.rd[7] & cmd_i.imm[7] & sbc_r[7]);
        next_status_register[FLAG_C]  = (~cmd_i.rd[7] & cmd_i.imm[7]) | (cmd_i.imm[7] & sbc_r[7]) |
                             (sbc_r[7] & ~cmd_i.rd[7]);
        next_status_register[FLAG_H]  = (~cmd_i.rd[3] & cmd_i.imm[3]) | (cmd_i.imm[3] & sbc_r[3]) |
                             (sbc_r[3] & ~cmd_i.rd[3]);
        next_status_register[FLAG_S]  = sbc_r[7] ^ ((cmd_i.rd[7] & ~cmd_i.imm[7] & ~sbc_r[7]) |
                             (~cmd_i.rd[7] & cmd_i.imm[7] & sbc_r[7]));
      end
      OP_MUL_SIGNED_BY_UNSIGNED: begin
        next_res.data     = p_su;                                          // [RULE8]
        next_res.wr_lo    = 1'b1;
        next_res.wr_hi    = 1'b1;
        next_res.dst_r10  = 1'b1;
        next_status_register[FLAG_Z] = (p_su == 16'h0000);
        next_status_register[FLAG_C] = p_su[15];
        next_n            = CYC_MUL;
      end
      OP_FRAC_MUL_SIGNED, OP_FRAC_MUL_SIGNED_UNSIGNED: begin
        next_res.data     = {p_frac[14:0], 1'b0};                          // [RULE9]
        next_res.wr_lo    = 1'b1;
        next_res.wr_hi    = 1'b1;
        next_res.dst_r10  = 1'b1;
        next_status_register[FLAG_Z] = (p_frac[14:0] == 15'h0000);
        next_status_register[FLAG_C] = p_frac[15];
        next_n            = CYC_MUL;
      end
      OP_INDIRECT_JUMP: begin
        next_res.pc      = {6'h00, cmd_i.zptr};                            // [RULE10]
        next_res.pc_load = 1'b1;
        next_n           = CYC_INDIRECT_JUMP;
      end
      OP_INDIRECT_CALL: begin
        next_res.pc         = {6'h00, cmd_i.zptr};                         // [RULE11]
        next_res.pc_load    = 1'b1;
        // A wide counter pushes a third return-address byte
        next_res.push_bytes = pc_wide ? PUSH_WIDE : PUSH_NARROW;           // [RULE22]
        next_n              = pc_wide ? CYC_CALL_WIDE : CYC_CALL_NARROW;   // [RULE11]
      end
      default: begin
      end
    endcase
  end

  // ------------------------------------------------------------
  // Sequencing: results commit after the operation's cycle count
  // ------------------------------------------------------------
  assign fin = (take && (next_n == CYC_BASE)) || (!ready_o && (cnt == 3'h1));

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ready_o   <= 1'b1;
      cnt       <= 3'h0;
      pend_res  <= '0;
      pend_status_register <= STATUS_RESET;
    end else if (take && (next_n != CYC_BASE)) begin
      ready_o   <= 1'b0;
      cnt       <= next_n - 3'h1;
      pend_res  <= next_res;
      pend_status_register <= next_status_register;
    end else if (!ready_o) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) begin
        ready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      res_o <= '0;
    end else if (fin) begin
      res_o <= take ? next_res : pend_res;
    end else begin
      res_o.done <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lastcyc <= 8'h00;
    end else if (take) begin
      lastcyc <= {5'h00, next_n};
    end
  end

  // ------------------------------------------------------------
  // Status register and register port
  // ------------------------------------------------------------
  // A commit wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      status_o <= STATUS_RESET;
    end else if (fin) begin
      status_o <= take ? next_status_register : pend_status_register;
    end else if (reg_we_i && (reg_addr_i == REG_STATUS)) begin
      status_o <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl <= CTRL_RESET;
    end else if (reg_we_i && (reg_addr_i == REG_CTRL)) begin
      ctrl <= {7'h00, reg_wdata_i[CTRL_PCWIDE]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        REG_CTRL:    reg_rdata_o <= ctrl;
        REG_STATUS:  reg_rdata_o <= status_o;
        REG_LASTCYC: reg_rdata_o <= lastcyc;
        default:     reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_word_add_time: assert property (take && cmd_i.op == OP_ADD_IMM_WORD |-> // [RULE1]
    ##1 !res_o.done ##1 (res_o.done && res_o.data == $past(w_add, 2) &&
    status_o[FLAG_H] == $past(status_o[FLAG_H], 2))) else $error("word add wrong");
  a_word_sub_time: assert property (take && cmd_i.op == OP_SUB_IMM_WORD |-> // [RULE2]
    ##1 !res_o.done ##1 (res_o.done && res_o.data == $past(w_sub, 2) &&
    status_o[FLAG_H] == $past(status_o[FLAG_H], 2))) else $error("word sub wrong");
  a_borrow_sub: assert property (take && cmd_i.op == OP_SUB_IMM_BORROW |=> // [RULE3]
    res_o.done && res_o.wr_lo && res_o.data[7:0] == $past(sbc_r)) else $error("sbc wrong");
  a_and_keep_c: assert property (take && cmd_i.op == OP_AND_IMM |=> // [RULE4]
    res_o.done && !status_o[FLAG_V] && status_o[FLAG_C] == $past(status_o[FLAG_C]) &&
    res_o.data[7:0] == $past(cmd_i.rd & cmd_i.imm)) else $error("and wrong");
  a_or_flags: assert property (take && cmd_i.op == OP_OR_IMM |=> // [RULE5]
    status_o[FLAG_Z] == (res_o.data[7:0] == 8'h00) && status_o[FLAG_N] == res_o.data[7])
    else $error("or flags wrong");
  a_set_bits: assert property (take && cmd_i.op == OP_SET_BITS_MASKED |=> // [RULE6]
    res_o.data[7:0] == $past(cmd_i.rd | cmd_i.imm) && status_o[FLAG_S] == res_o.data[7])
    else $error("set bits wrong");
  a_test_keep: assert property (take && cmd_i.op == OP_TEST_REG |=> // [RULE7]
    res_o.done && !res_o.wr_lo && status_o[FLAG_Z] == ($past(cmd_i.rd) == 8'h00))
    else $error("test wrong");
  a_mul_su: assert property (take && cmd_i.op == OP_MUL_SIGNED_BY_UNSIGNED |-> // [RULE8]
    ##1 !res_o.done ##1 (res_o.done && res_o.dst_r10 && res_o.data == $past(p_su, 2) &&
    status_o[FLAG_C] == res_o.data[15])) else $error("mul_signed_by_unsigned wrong");
  a_frac_mul: assert property (take && cmd_i.op == OP_FRAC_MUL_SIGNED |-> // [RULE9]
    ##2 (res_o.data == {$past(p_ss[14:0], 2), 1'b0} &&
    status_o[FLAG_C] == $past(p_ss[15], 2))) else $error("frac_mul_signed wrong");
  a_ind_jump: assert property (take && cmd_i.op == OP_INDIRECT_JUMP |-> // [RULE10]
    ##1 !res_o.done ##1 (res_o.done && res_o.pc == {6'h00, $past(cmd_i.zptr, 2)} &&
    status_o == $past(status_o, 2))) else $error("indirect_jump wrong");
  a_call_narrow: assert property (take && cmd_i.op == OP_INDIRECT_CALL && !pc_wide |-> // [RULE11]
    ##1 !res_o.done [*2] ##1 (res_o.done && res_o.pc[21:16] == 6'h00))
    else $error("indirect_call narrow wrong");
  a_call_wide: assert property (take && cmd_i.op == OP_INDIRECT_CALL && pc_wide |-> // [RULE22]
    ##1 !res_o.done [*3] ##1 (res_o.done && res_o.push_bytes == PUSH_WIDE))
    else $error("indirect_call wide wrong");
  a_compare_skip_equal_skip: assert property (take && cmd_i.op == OP_COMPARE_SKIP_EQUAL && // [RULE12]
    cmd_i.rd == cmd_i.rr && !cmd_i.next_two_word |-> ##1 !res_o.done ##1
    (res_o.done && res_o.pc == $past(cmd_i.pc, 2) + 22'h000002 &&
    status_o == $past(status_o, 2))) else $error("compare_skip_equal wrong");
  a_skip_reg_bit_clear_noskip: assert property (take && cmd_i.op == OP_SKIP_REG_BIT_CLEAR && // [RULE13]
    cmd_i.rd[cmd_i.bitsel] |=> res_o.done && res_o.pc == $past(pc_inc))
    else $error("skip_reg_bit_clear wrong");
  a_skip_io_bit_set_flags: assert property (take && cmd_i.op == OP_SKIP_IO_BIT_SET && // [RULE14]
    cmd_i.io_val[cmd_i.bitsel] && !cmd_i.next_two_word |-> ##2 (res_o.done &&
    status_o == $past(status_o, 2)))
    else $error("skip_io_bit_set wrong");
  a_skip_two: assert property (take && is_skip && skip_hit && cmd_i.next_two_word |-> // [RULE23]
    ##1 !res_o.done [*2] ##1 (res_o.done && res_o.pc == $past(cmd_i.pc, 3) + 22'h000003))
    else $error("skip two wrong");
  a_branch_flag_set_fall: assert property (take && cmd_i.op == OP_BRANCH_FLAG_SET && // [RULE15]
    !status_o[cmd_i.bitsel] |=> res_o.done && !res_o.pc_load && res_o.pc == $past(pc_inc))
    else $error("branch_flag_set wrong");
  a_branch_signed_ge_taken: assert property (take && cmd_i.op == OP_BRANCH_SIGNED_GE && // [RULE16]
    status_o[FLAG_N] == status_o[FLAG_V] |-> ##2 (res_o.done && res_o.pc == $past(pc_rel, 2)))
    else $error("branch_signed_ge wrong");
  a_branch_signed_lt_time: assert property (take && cmd_i.op == OP_BRANCH_SIGNED_LT && // [RULE17]
    status_o[FLAG_N] != status_o[FLAG_V] |-> ##1 !res_o.done ##1 res_o.done)
    else $error("branch_signed_lt wrong");
  a_branch_unsigned_ge_fall: assert property (take && cmd_i.op == OP_BRANCH_UNSIGNED_GE && // [RULE18]
    status_o[FLAG_C] |=> res_o.done && !res_o.pc_load) else $error("branch_unsigned_ge wrong");
  a_branch_halfcarry_set_taken: assert property (take && cmd_i.op == OP_BRANCH_HALFCARRY_SET && // [RULE19]
    status_o[FLAG_H] |-> ##2 res_o.pc_load) else $error("branch_halfcarry_set wrong");
  a_branch_overflow_set_fall: assert property (take && cmd_i.op == OP_BRANCH_OVERFLOW_SET && // [RULE20]
    !status_o[FLAG_V] |=> res_o.done && res_o.pc == $past(pc_inc)) else $error("branch_overflow_set wrong");
  a_branch_irq_enabled_flags: assert property (take && cmd_i.op == OP_BRANCH_IRQ_ENABLED && // [RULE21]
    status_o[FLAG_I] |-> ##2 (res_o.pc_load && status_o == $past(status_o, 2)))
    else $error("branch_irq_enabled wrong");

  c_word_op:    cover property (take && cmd_i.op == OP_ADD_IMM_WORD ##2 res_o.done);
  c_call_wide:  cover property (take && cmd_i.op == OP_INDIRECT_CALL && pc_wide);
  c_skip_two:   cover property (take && is_skip && skip_hit && cmd_i.next_two_word);
  c_back2back:  cover property (take ##1 take);

endmodule : cab_alu_branch

// File: hdl/cab_pkg.sv
package cab_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W = 22;

  // ----------------------------------------------------------------
  // Register port map (8-bit registers)
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_CTRL    = 2'h0;
  localparam logic [1:0] REG_STATUS  = 2'h1;
  localparam logic [1:0] REG_LASTCYC = 2'h2;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] CTRL_PCWIDE  = 3'h0;

  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ----------------------------------------------------------------
  // Cycle counts and return-address push byte counts
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_BASE        = 3'h1;
  localparam logic [2:0] CYC_WORD        = 3'h2;
  localparam logic [2:0] CYC_MUL         = 3'h2;
  localparam logic [2:0] CYC_INDIRECT_JUMP        = 3'h2;
  localparam logic [2:0] CYC_CALL_NARROW = 3'h3;
  localparam logic [2:0] CYC_CALL_WIDE   = 3'h4;
  localparam logic [2:0] CYC_BR_TAKEN    = 3'h2;
  localparam logic [2:0] CYC_SKIP_ONE    = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO    = 3'h3;
  localparam logic [1:0] PUSH_NARROW     = 2'h2;
  localparam logic [1:0] PUSH_WIDE       = 2'h3;

  typedef enum logic [4:0] {
    OP_ADD_IMM_WORD, OP_SUB_IMM_WORD, OP_SUB_IMM_BORROW, OP_AND_IMM, OP_OR_IMM,
    OP_SET_BITS_MASKED, OP_TEST_REG, OP_MUL_SIGNED_BY_UNSIGNED, OP_FRAC_MUL_SIGNED,
    OP_FRAC_MUL_SIGNED_UNSIGNED, OP_INDIRECT_JUMP, OP_INDIRECT_CALL,
    OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
    OP_BRANCH_UNSIGNED_GE, OP_BRANCH_HALFCARRY_SET, OP_BRANCH_OVERFLOW_SET,
    OP_BRANCH_IRQ_ENABLED
  } cab_op_t;

  typedef struct packed {
    cab_op_t          op;
    logic [7:0]       rd;
    logic [7:0]       rr;
    logic [15:0]      pair;
    logic [7:0]       imm;
    logic [2:0]       bitsel;
    logic [7:0]       io_val;
    logic [15:0]      zptr;
    logic [PC_W-1:0]  pc;
    logic [6:0]       offset;
    logic             next_two_word;
  } cab_cmd_t;

  typedef struct packed {
    logic             done;
    logic             wr_lo;
    logic             wr_hi;
    logic             dst_r10;
    logic [15:0]      data;
    logic             pc_load;
    logic [PC_W-1:0]  pc;
    logic [1:0]       push_bytes;
    logic [PC_W-1:0]  ret_pc;
  } cab_res_t;

endpackage : cab_pkg

// File: verif/tb_cab_alu_branch.sv
`timescale 1ns/1ps
module tb_cab_alu_branch;
  import cab_pkg::*;
  logic            clk_i, resetn_i, cmd_valid_i, ready_o, reg_we_i, reg_re_i, wl, wide;
  cab_cmd_t        cmd_i;
  cab_res_t        res_o;
  logic [7:0]      status_o, reg_wdata_i, reg_rdata_o, st, es;
  logic [1:0]      reg_addr_i;
  logic [15:0]     ed, em;
  logic [PC_W-1:0] ep;
  logic [2:0]      en;
  logic [31:0]     rnd;
  int              num_errors = 0, check_count = 0;
  cab_alu_branch cab_alu_branch_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .ready_o(ready_o), .res_o(res_o),
    .status_o(status_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));
  always #2.5 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // Expected results
  // ----------------------------------------------------------------
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic void model(input cab_cmd_t c);
    logic [15:0] r;
    logic [7:0]  d;
    logic [7:0]  k;
    logic        t;
    logic        q;
    {d, k, t, q, r} = {c.rd, c.imm, c.op == OP_ADD_IMM_WORD, 17'h0};
    {es, en, ep, em, wl} = {st, 3'h1, c.pc + 22'h1, 16'h0, 1'b0};
    case (c.op)
      OP_ADD_IMM_WORD, OP_SUB_IMM_WORD: begin
        r = t ? c.pair + c.imm[5:0] : c.pair - c.imm[5:0];
        es[3:0] = {t ? ~c.pair[15] & r[15] : c.pair[15] & ~r[15], r[15], r == 16'h0,
                   t ? c.pair[15] & ~r[15] : r[15] & ~c.pair[15]};
        {en, em, wl, q} = {3'h2, 16'hffff, 2'b11};
      end
      OP_SUB_IMM_BORROW: begin
        r = d - k - st[0];
        es[5] = ~d[3] & k[3] | k[3] & r[3] | r[3] & ~d[3];
        es[3:0] = {d[7] & ~k[7] & ~r[7] | ~d[7] & k[7] & r[7], r[7], r[7:0] == 8'h0 && st[1],
                   ~d[7] & k[7] | k[7] & r[7] | r[7] & ~d[7]};
        {em, wl, q} = {16'h00ff, 2'b11};
      end
      OP_AND_IMM, OP_OR_IMM, OP_SET_BITS_MASKED, OP_TEST_REG: begin
        r[7:0] = c.op == OP_AND_IMM ? d & k : c.op == OP_TEST_REG ? d : d | k;
        es[3:1] = {1'b0, r[7], r[7:0] == 8'h0};
        {em, wl, q} = {16'h00ff, c.op != OP_TEST_REG, 1'b1};
      end
      OP_MUL_SIGNED_BY_UNSIGNED, OP_FRAC_MUL_SIGNED, OP_FRAC_MUL_SIGNED_UNSIGNED: begin
        r = $signed(d) * (c.op == OP_FRAC_MUL_SIGNED ? $signed(c.rr) : $signed({1'b0, c.rr}));
        es[0] = r[15];
        r = c.op == OP_MUL_SIGNED_BY_UNSIGNED ? r : r << 1;
        es[1] = r == 16'h0;
        {en, em, wl} = {3'h2, 16'hffff, 1'b1};
      end
      OP_INDIRECT_JUMP, OP_INDIRECT_CALL: begin
        ep = {6'h0, c.zptr};
        en = c.op == OP_INDIRECT_JUMP ? 3'h2 : wide ? 3'h4 : 3'h3;
      end
      default: begin
        case (c.op)
          OP_COMPARE_SKIP_EQUAL: t = d == c.rr;
          OP_SKIP_REG_BIT_CLEAR: t = ~c.rr[c.bitsel];
          OP_SKIP_IO_BIT_SET: t = c.io_val[c.bitsel];
          OP_BRANCH_FLAG_SET: t = st[c.bitsel];
          OP_BRANCH_SIGNED_GE: t = ~(st[2] ^ st[3]);
          OP_BRANCH_SIGNED_LT: t = st[2] ^ st[3];
          OP_BRANCH_UNSIGNED_GE: t = ~st[0];
          OP_BRANCH_HALFCARRY_SET: t = st[5];
          OP_BRANCH_OVERFLOW_SET: t = st[3];
          default: t = st[7];
        endcase
        if (t && c.op < OP_BRANCH_FLAG_SET) begin
          en = c.next_two_word ? 3'h3 : 3'h2;
          ep = c.pc + (c.next_two_word ? 22'h3 : 22'h2);
        end else if (t) begin
          en = 3'h2;
          ep = c.pc + {{15{c.offset[6]}}, c.offset} + 22'h1;
        end
      end
    endcase
    if (q) es[4] = es[2] ^ es[3];
    ed = r;
  endfunction : model
  function automatic cab_cmd_t rc(input cab_op_t op);
    logic [127:0] v;
    for (int j = 0; j < 4; j++) begin
      rnd = nx(rnd);
      v[j*32 +: 32] = rnd;
    end
    rc = cab_cmd_t'(v[$bits(cab_cmd_t)-1:0]);
    rc.op = op;
    if (op < OP_SUB_IMM_BORROW) rc.imm[7:6] = 2'h0;
    if (op == OP_SKIP_REG_BIT_CLEAR || v[127]) rc.rd = rc.rr;
  endfunction : rc
  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task close_out;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic wrr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {reg_we_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_i);
    {reg_re_i, reg_addr_i} <= {1'b1, a};
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 chk(reg_rdata_o === e, "register read");
  endtask : rdr
  task automatic run(input cab_cmd_t c);
    int n = 0;
    model(c);
    @(posedge clk_i);
    {cmd_valid_i, cmd_i} <= {1'b1, c};
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    // Done of a one-cycle op already stands just after the take edge
    #1 n = 1;
    while (res_o.done !== 1'b1 && n < 8) begin
      chk(ready_o === 1'b0, "taken while busy");
      @(posedge clk_i);
      #1 n++;
    end
    if (res_o.done !== 1'b1) begin
      num_errors++;
      close_out;
    end
    chk(n == en, "cycle count");
    chk(status_o === es, "status flags");
    chk(res_o.pc === ep, "next pc");
    chk((res_o.data & em) === (ed & em) && res_o.wr_lo === wl, "data");
    chk(res_o.wr_hi === em[15], "high byte write");
    chk(res_o.dst_r10 === (c.op > OP_TEST_REG && c.op < OP_INDIRECT_JUMP), "pair");
    if (c.op == OP_INDIRECT_CALL) chk(res_o.ret_pc === c.pc + 22'h1, "return pc");
    if (c.op == OP_INDIRECT_CALL) chk(res_o.push_bytes === {1'b1, wide}, "push");
    st = es;
  endtask : run
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    {clk_i, resetn_i, cmd_valid_i, cmd_i, reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i} = '0;
    {rnd, st, wide} = {32'hb30f, 9'h0};
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdr(REG_STATUS, STATUS_RESET);
    wrr(REG_CTRL, 8'hfe);
    rdr(REG_CTRL, 8'h00);
    rdr(2'h3, 8'h00);
    run(rc(OP_ADD_IMM_WORD) | 102'h0);
    for (int i = 0; i < 400; i++) begin
      rnd = nx(rnd);
      if (rnd[2:0] == 3'h0) wrr(REG_STATUS, rnd[15:8]);
      if (rnd[2:0] == 3'h0) st = rnd[15:8];
      if (rnd[6:3] == 4'h0) wrr(REG_CTRL, {7'h0, rnd[9]});
      if (rnd[6:3] == 4'h0) wide = rnd[9];
      run(rc(cab_op_t'(5'(rnd[31:16] % 22))));
      if (rnd[5:3] == 3'h1) rdr(REG_LASTCYC, {5'h0, en});
      if (rnd[5:3] == 3'h2) rdr(REG_STATUS, st);
    end
    close_out;
  end
endmodule : tb_cab_alu_branch
